//--- common/sync_source_pkg.sv
// Constants, codes and carrier types for the compare sync source selector
package sync_source_pkg;

   // ----------------------------------------------------------------
   // Register bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_WIDTH = 4;              // Register address width
   localparam int DATA_WIDTH = 16;             // Register data width

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_WIDTH-1:0] OFS_SYNC_CONTROL = 4'h0; // Source select
   localparam logic [ADDR_WIDTH-1:0] OFS_UNIT_CONTROL = 4'h1; // Unit on/off
   localparam logic [ADDR_WIDTH-1:0] OFS_UNIT_STATUS  = 4'h2; // Status flags

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SEL_LSB       = 0;           // Select field low bit
   localparam int SEL_MSB       = 4;           // Select field high bit
   localparam int ENABLE_BIT    = 0;           // Unit enable bit
   localparam int SEEN_BIT      = 0;           // Sticky event seen
   localparam int SELF_BIT      = 1;           // Own unit selected
   localparam int INERT_BIT     = 2;           // Inert code selected

   // ----------------------------------------------------------------
   // Selection codes
   // ----------------------------------------------------------------
   localparam logic [4:0] SEL_NONE      = 5'h00; // No source
   localparam logic [4:0] SEL_OC_FIRST  = 5'h01; // Compare unit one
   localparam logic [4:0] SEL_OC_LAST   = 5'h04; // Compare unit four
   localparam logic [4:0] SEL_TRIG_GEN  = 5'h0A; // Trigger generator output
   localparam logic [4:0] SEL_TMR_FIRST = 5'h0B; // Timer one
   localparam logic [4:0] SEL_IC_FIRST  = 5'h10; // Input capture one
   localparam logic [4:0] SEL_CMP_FIRST = 5'h18; // Analog comparator one
   localparam logic [4:0] SEL_ADC       = 5'h1B; // Converter
   localparam logic [4:0] SEL_CHARGE_TIME_MEASURE_BLOCK      = 5'h1C; // Charge time block
   localparam logic [4:0] SEL_IRQ_ONE   = 5'h1D; // External pin one
   localparam logic [4:0] SEL_IRQ_TWO   = 5'h1E; // External pin two
   localparam logic [4:0] SEL_OWN_MATCH = 5'h1F; // Own secondary match

   // ----------------------------------------------------------------
   // Counts and reset values
   // ----------------------------------------------------------------
   localparam int NUM_CODES   = 32;            // Codes of the select field
   localparam int NUM_UNITS   = 4;             // Compare units
   localparam int NUM_TIMERS  = 5;             // Timers
   localparam int NUM_CAPTURE = 4;             // Capture units
   localparam int NUM_CMP     = 3;             // Analog comparators
   localparam logic [4:0] SEL_RESET = 5'h0C;   // Timer two after reset

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_WIDTH-1:0] addr;             // Register index
      logic [DATA_WIDTH-1:0] wdata;            // Write data
      logic                  write;            // Write strobe
      logic                  read;             // Read strobe
   } reg_req_s;

   typedef struct packed {
      logic                   own_match;                 // Own match pulse
      logic                   external_irq_pin_one;      // Pin one level
      logic                   external_irq_pin_two;      // Pin two level
      logic                   charge_time_measure_block; // Charge time event
      logic                   adc_event;                 // Converter event
      logic [NUM_CMP-1:0]     analog_comparator;         // Comparators 1..3
      logic [NUM_CAPTURE-1:0] input_capture;             // Captures 1..4
      logic [NUM_TIMERS-1:0]  timer_event;               // Timers 1..5
      logic [NUM_UNITS-1:0]   trigger_generator_output;  // Generator 0..3
      logic [NUM_UNITS-1:0]   other_compare_unit;        // Trigger outs 1..4
   } source_events_s;

endpackage

//--- logic/event_edge_sync.sv
// Two-stage synchroniser with rising edge detection for a vector of events
`timescale 1ns/1ps

module event_edge_sync
#(
   parameter int WIDTH = 32                   // Number of event lines
)
(
   input  wire logic             clk_sys,     // System clock
   input  wire logic             rst,         // Synchronous reset
   input  wire logic [WIDTH-1:0] event_in,    // Raw event levels
   output      logic [WIDTH-1:0] event_pulse  // One-cycle rising edges
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (WIDTH < 1)
   begin : g_bad_width
      $error("event_edge_sync: WIDTH must be at least one");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] stage_one;            // First synchroniser stage
      logic [WIDTH-1:0] stage_two;            // Second synchroniser stage
      logic [WIDTH-1:0] previous;             // Stage two one cycle ago
   } edge_state_s;

   edge_state_s state;                        // Registered state
   edge_state_s next_state;                   // Next state

   // Shift the chain; stage one feeds only stage two
   always_comb
   begin
      next_state           = state;
      next_state.stage_one = event_in;
      next_state.stage_two = state.stage_one;
      next_state.previous  = state.stage_two;
   end

   // Register the state
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Edge seen after synchronisation
   assign event_pulse = state.stage_two & ~state.previous;

endmodule // event_edge_sync

//--- logic/compare_sync_source_select.sv
// Sync and trigger source selection for one output compare unit
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps


module compare_sync_source_select
#(
   parameter int UNIT_INDEX = 1               // This unit, one to four
)
(
   input  wire logic                             clk_sys,
   input  wire logic                             rst,
   input  wire sync_source_pkg::reg_req_s        reg_req,
   output      logic [sync_source_pkg::DATA_WIDTH-1:0] reg_rdata,
   input  wire sync_source_pkg::source_events_s  src,
   output      logic                             sync_event,
   output      logic                             trigger_out,
   output      logic                             unit_enabled
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (UNIT_INDEX < 1 || UNIT_INDEX > sync_source_pkg::NUM_UNITS)
   begin : g_bad_unit
      $error("compare_sync_source_select: UNIT_INDEX out of range");
   end

   // The field must span the code space and each source group its codes
   if (sync_source_pkg::NUM_CODES != 2 ** (sync_source_pkg::SEL_MSB + 1) ||
       sync_source_pkg::NUM_UNITS != 4 || sync_source_pkg::NUM_TIMERS != 5 ||
       sync_source_pkg::NUM_CAPTURE != 4 || sync_source_pkg::NUM_CMP != 3)
   begin : g_bad_layout
      $error("compare_sync_source_select: package counts do not fit the codes");
   end

   // Code that would name this unit as its own source
   localparam logic [4:0] SEL_SELF =
      5'(sync_source_pkg::SEL_OC_FIRST + UNIT_INDEX - 1);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------

   // True when a code is one of the reserved, inert ones
   // Reserved codes sit in two gaps of the code space
   function automatic logic code_is_inert(input logic [4:0] code);
      logic low_gap;                          // Between units and generator
      logic high_gap;                         // Between captures and comparators

      begin
         low_gap  = (code > sync_source_pkg::SEL_OC_LAST) &&
                    (code < sync_source_pkg::SEL_TRIG_GEN);
         high_gap = (code >= 5'h14) &&
                    (code < sync_source_pkg::SEL_CMP_FIRST);
         code_is_inert = low_gap || high_gap;
      end
   endfunction

   // True when a code routes a live source to this unit
   function automatic logic code_is_live(input logic [4:0] code);
      begin
         code_is_live = (code != sync_source_pkg::SEL_NONE) &&
                        !code_is_inert(code) &&
                        (code != SEL_SELF);
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0]                         sel;        // Source select
      logic                               enabled;    // Unit switched on
      logic                               seen;       // Sticky event flag
      logic                               sync_event; // Sync pulse out
      logic                               trig_out;   // Trigger out pulse
      logic [sync_source_pkg::DATA_WIDTH-1:0] rdata;  // Read data
   } sel_state_s;

   sel_state_s state;                         // Registered state
   sel_state_s next_state;                    // Next state

   // ----------------------------------------------------------------
   // Event vector indexed by selection code
   // ----------------------------------------------------------------
   logic [sync_source_pkg::NUM_CODES-1:0] raw_events;   // Raw levels
   logic [sync_source_pkg::NUM_CODES-1:0] event_pulses; // Synced edges

   // Place each source at the index equal to its code
   // Codes with no source stay low, so reserved codes can never pulse
   always_comb
   begin
      raw_events = '0;

      // Other compare units' trigger outs
      for (int i = 0; i < sync_source_pkg::NUM_UNITS; i++)
      begin
         raw_events[32'(sync_source_pkg::SEL_OC_FIRST) + i] =
            src.other_compare_unit[i];
      end

      // Generator output dedicated to this unit
      raw_events[sync_source_pkg::SEL_TRIG_GEN] =
         src.trigger_generator_output[UNIT_INDEX-1];

      // Timers in ascending order
      for (int i = 0; i < sync_source_pkg::NUM_TIMERS; i++)
      begin
         raw_events[32'(sync_source_pkg::SEL_TMR_FIRST) + i] =
            src.timer_event[i];
      end

      // Capture events in ascending order
      for (int i = 0; i < sync_source_pkg::NUM_CAPTURE; i++)
      begin
         raw_events[32'(sync_source_pkg::SEL_IC_FIRST) + i] =
            src.input_capture[i];
      end

      // Comparators in ascending order
      for (int i = 0; i < sync_source_pkg::NUM_CMP; i++)
      begin
         raw_events[32'(sync_source_pkg::SEL_CMP_FIRST) + i] =
            src.analog_comparator[i];
      end

      // Single sources at the top of the code space
      raw_events[sync_source_pkg::SEL_ADC]  = src.adc_event;
      raw_events[sync_source_pkg::SEL_CHARGE_TIME_MEASURE_BLOCK] =
         src.charge_time_measure_block;
      raw_events[sync_source_pkg::SEL_IRQ_ONE] =
         src.external_irq_pin_one;
      raw_events[sync_source_pkg::SEL_IRQ_TWO] =
         src.external_irq_pin_two;
      raw_events[sync_source_pkg::SEL_OWN_MATCH] =
         src.own_match;
   end

   // Synchronise every line and find its rising edge
   // The mux sits behind the chain: one chain serves every code, and a
   // select change also acts on edges already in flight
   event_edge_sync
   #(
      .WIDTH       (sync_source_pkg::NUM_CODES)
   )
   u_edge_sync
   (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .event_in    (raw_events),
      .event_pulse (event_pulses)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic sel_live;                            // Current code is routable
   logic picked;                              // Selected line pulsed
   logic write_enable;                        // Unit control written
   logic clear_seen;                          // Software clears flag

   // Decode bus access and the selected event
   // A unit that names itself is treated as having no source
   always_comb
   begin
      sel_live     = code_is_live(state.sel);
      picked       = sel_live && event_pulses[state.sel];
      write_enable = reg_req.write &&
                     (reg_req.addr == sync_source_pkg::OFS_UNIT_CONTROL);
      clear_seen   = reg_req.write &&
                     (reg_req.addr == sync_source_pkg::OFS_UNIT_STATUS) &&
                     reg_req.wdata[sync_source_pkg::SEEN_BIT];
   end

   // Compute the next state
   always_comb
   begin
      next_state = state;

      // Select field write; upper bits are not stored
      if (reg_req.write &&
          (reg_req.addr == sync_source_pkg::OFS_SYNC_CONTROL))
      begin
         next_state.sel =
            reg_req.wdata[sync_source_pkg::SEL_MSB:
                          sync_source_pkg::SEL_LSB];
      end

      // Unit on/off and the trigger pulse on switch-off
      // Units that select this one still take the pulse; software must
      // deselect this unit there before switching it off
      next_state.trig_out = 1'b0;
      if (write_enable)
      begin
         next_state.enabled =
            reg_req.wdata[sync_source_pkg::ENABLE_BIT];
         // Falling from on to off
         if (state.enabled &&
             !reg_req.wdata[sync_source_pkg::ENABLE_BIT])
         begin
            next_state.trig_out = 1'b1;
         end
      end

      // Sync pulse follows the selected source
      next_state.sync_event = picked;

      // Sticky flag: a new event beats a clear
      // so an event that lands with the clear is never lost
      if (picked)
      begin
         next_state.seen = 1'b1;
      end
      else if (clear_seen)
      begin
         next_state.seen = 1'b0;
      end

      // Read data for the cycle after the strobe
      // and zero in every other cycle
      next_state.rdata = '0;
      if (reg_req.read)
      begin
         case (reg_req.addr)
            // Select field in the low bits
            sync_source_pkg::OFS_SYNC_CONTROL:
            begin
               next_state.rdata[sync_source_pkg::SEL_MSB:
                                sync_source_pkg::SEL_LSB] = state.sel;
            end

            // Enable bit
            sync_source_pkg::OFS_UNIT_CONTROL:
            begin
               next_state.rdata[sync_source_pkg::ENABLE_BIT] =
                  state.enabled;
            end

            // Status flags
            sync_source_pkg::OFS_UNIT_STATUS:
            begin
               next_state.rdata[sync_source_pkg::SEEN_BIT] = state.seen;
               next_state.rdata[sync_source_pkg::SELF_BIT] =
                  (state.sel == SEL_SELF);
               next_state.rdata[sync_source_pkg::INERT_BIT] =
                  code_is_inert(state.sel);
            end

            // Unmapped reads return zero
            default:
            begin
               next_state.rdata = '0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Register the whole state; reset selects timer two
   // The synchroniser shares this reset, so no stale edge follows it
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state            <= '0;
         state.sel        <= sync_source_pkg::SEL_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   // Pulses last one cycle; the enable level holds until rewritten
   assign reg_rdata    = state.rdata;         // Read data
   assign sync_event   = state.sync_event;    // Selected event pulse
   assign trigger_out  = state.trig_out;      // Switch-off pulse
   assign unit_enabled = state.enabled;       // Unit on

endmodule // compare_sync_source_select

//--- testbench/compare_sync_properties.sv
// Checker for the compare sync source selector, bound to its ports
`timescale 1ns/1ps

module compare_sync_checker
#(
   parameter int UNIT_INDEX = 1                  // Unit under check
)
(
   input wire logic                                  clk_sys,
   input wire logic                                  rst,
   input wire sync_source_pkg::reg_req_s             reg_req,
   input wire logic [sync_source_pkg::DATA_WIDTH-1:0] reg_rdata,
   input wire sync_source_pkg::source_events_s       src,
   input wire logic                                  sync_event,
   input wire logic                                  trigger_out,
   input wire logic                                  unit_enabled
);
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   logic [4:0]  sel;                             // Mirror of select field
   logic [3:0]  sel_age;                         // Cycles since select write
   logic [24:0] prev_src;                        // Source levels last cycle
   logic [24:0] src_v;                           // Flat source levels
   logic        rise;                            // Routed line rose
   logic        sel_wr;                          // Select write this cycle

   // Line routed by a code, empty for none, reserved and own unit
   function automatic logic [24:0] line_mask(input logic [4:0] c);
      logic [24:0] m;
      m = '0;
      if (c >= 5'h01 && c <= 5'h04 && c != UNIT_INDEX) m[c-1] = 1'b1;
      else if (c == 5'h0A) m[3+UNIT_INDEX] = 1'b1;
      else if (c >= 5'h0B && c <= 5'h0F) m[c-3] = 1'b1;
      else if (c >= 5'h10 && c <= 5'h13) m[c-3] = 1'b1;
      else if (c >= 5'h18 && c <= 5'h1C) m[c-7] = 1'b1;
      else if (c == 5'h1D) m[23] = 1'b1;
      else if (c == 5'h1E) m[22] = 1'b1;
      else if (c == 5'h1F) m[24] = 1'b1;
      return m;
   endfunction

   assign src_v  = src;
   assign rise   = |(line_mask(sel) & src_v & ~prev_src);
   assign sel_wr = reg_req.write && reg_req.addr == sync_source_pkg::OFS_SYNC_CONTROL;

   // Track select field and its age, and last source levels
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sel      <= sync_source_pkg::SEL_RESET;
         sel_age  <= 4'h0;
         prev_src <= '0;
      end
      else
      begin
         prev_src <= src_v;
         if (sel_wr)
         begin
            sel     <= reg_req.wdata[4:0];
            sel_age <= 4'h0;
         end
         else if (sel_age != 4'hF) sel_age <= sel_age + 4'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_select_readback: assert property (
      $past(reg_req.read && reg_req.addr == sync_source_pkg::OFS_SYNC_CONTROL)
      |-> reg_rdata == {11'h000, $past(sel)}) else $error("select read back wrong");
   a_rdata_idle: assert property (!$past(reg_req.read) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   a_sync_follows: assert property ((rise && sel_age >= 4) |-> ##3 sync_event)
      else $error("routed event not delivered");
   a_sync_cause: assert property ((sync_event && sel_age >= 7) |-> $past(rise, 3))
      else $error("sync pulse without routed event");
   a_sync_single: assert property (sync_event |=> !sync_event)
      else $error("sync pulse longer than one cycle");
   a_none_silent: assert property (
      (line_mask(sel) == 25'h0 && sel_age >= 4) |-> !sync_event)
      else $error("sync pulse with no source");
   a_trigger_off: assert property (
      (reg_req.write && reg_req.addr == sync_source_pkg::OFS_UNIT_CONTROL
       && !reg_req.wdata[0] && unit_enabled) |=> trigger_out && !unit_enabled)
      else $error("no trigger out on switch off");
   a_trigger_cause: assert property (
      trigger_out |-> $past(unit_enabled) && $past(reg_req.write)
      && $past(reg_req.addr) == sync_source_pkg::OFS_UNIT_CONTROL
      && !$past(reg_req.wdata[0]))
      else $error("trigger out without switch off");
   a_trigger_single: assert property (trigger_out |=> !trigger_out)
      else $error("trigger out longer than one cycle");

   c_sync: cover property (rise && sel_age >= 4 ##3 sync_event);
   c_trigger: cover property (trigger_out);
   c_none: cover property (line_mask(sel) == 25'h0 && |(src_v & ~prev_src));

endmodule // compare_sync_checker

bind compare_sync_source_select compare_sync_checker #(.UNIT_INDEX(UNIT_INDEX)) chk_inst (
   .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .src(src),
   .sync_event(sync_event), .trigger_out(trigger_out), .unit_enabled(unit_enabled));

//--- testbench/source_model.sv
// Far side model: raises one source line for two cycles on request
`timescale 1ns/1ps

module source_model
(
   input  wire logic                            clk_sys, // System clock
   input  wire logic [24:0]                     fire,    // One-cycle line request
   output      sync_source_pkg::source_events_s src      // Source levels
);
   logic [24:0] hold_a;                          // First high cycle
   logic [24:0] hold_b;                          // Second high cycle

   // Two-cycle level, then low again so each request is one rising edge
   always_ff @(posedge clk_sys)
   begin
      hold_a <= fire;
      hold_b <= hold_a;
   end
   assign src = hold_a | hold_b;
endmodule // source_model

//--- testbench/tb_top.sv
// Self-checking testbench for the compare sync source selector
`timescale 1ns/1ps

module tb_top;
   localparam int UNIT = 2;                      // Unit index under test
   logic                            clk_sys;     // System clock
   logic                            rst;         // Synchronous reset
   sync_source_pkg::reg_req_s       req;         // Register request
   logic [15:0]                     reg_rdata;   // Read data
   sync_source_pkg::source_events_s src;         // Source levels
   logic [24:0]                     fire;        // Model line requests
   logic                            sync_event;  // Delivered event
   logic                            trigger_out; // Switch-off pulse
   logic                            unit_enabled;// Enable level
   int                              miscompares; // Mismatch count
   int                              checked;     // Comparison count
   logic [15:0]                     d;           // Last read data
   int                              n;           // Pulse count

   compare_sync_source_select #(.UNIT_INDEX(UNIT)) compare_sync_source_select_inst (
      .clk_sys(clk_sys), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata), .src(src),
      .sync_event(sync_event), .trigger_out(trigger_out), .unit_enabled(unit_enabled));
   source_model source_model_inst (.clk_sys(clk_sys), .fire(fire), .src(src));

   // ----------------------------------------------------------------
   // Clock, compare and bus tasks
   // ----------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      req.write <= 1'b1;
      req.addr  <= a;
      req.wdata <= v;
      @(posedge clk_sys);
      req.write <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      req.read <= 1'b1;
      req.addr <= a;
      @(posedge clk_sys);
      req.read <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Pulse one source line and count sync pulses that follow
   task automatic pulse(input int l);
      @(posedge clk_sys);
      fire <= 25'h0000001 << l;
      @(posedge clk_sys);
      fire <= '0;
      n = 0;
      repeat (7)
      begin
         @(posedge clk_sys);
         #1 if (sync_event === 1'b1) n++;
      end
   endtask

   // Expected line for a code, -1 where nothing is routed
   function automatic int route_idx(input int c);
      if (c >= 1 && c <= 4) return (c == UNIT) ? -1 : c - 1;
      if (c == 10) return 3 + UNIT;
      if (c >= 11 && c <= 19) return c - 3;
      if (c >= 24 && c <= 28) return c - 7;
      if (c == 29) return 23;
      if (c == 30) return 22;
      if (c == 31) return 24;
      return -1;
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rd(4'h0);
      chk16(d, 16'h000C);
      rd(4'h1);
      chk16(d, 16'h0000);
      rd(4'h2);
      chk16(d, 16'h0000);
      rd(4'hF);
      chk16(d, 16'h0000);
      chk1(unit_enabled, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_field;
      wr(4'h0, 16'hFFFF);
      rd(4'h0);
      chk16(d, 16'h001F);
      wr(4'hF, 16'h1234);
      rd(4'h0);
      chk16(d, 16'h001F);
      $display("test field done");
   endtask

   task automatic t_status;
      wr(4'h0, 16'(UNIT));
      rd(4'h2);
      chk16(d, 16'h0002);
      wr(4'h0, 16'h0007);
      rd(4'h2);
      chk16(d, 16'h0004);
      wr(4'h0, 16'h000C);
      pulse(9);
      chk16(n[15:0], 16'h0001);
      rd(4'h2);
      chk16(d, 16'h0001);
      wr(4'h2, 16'h0001);
      rd(4'h2);
      chk16(d, 16'h0000);
      $display("test status done");
   endtask

   // Every code against every source line
   task automatic t_route;
      for (int c = 0; c < 32; c++)
      begin
         wr(4'h0, c[15:0]);
         repeat (4) @(posedge clk_sys);
         for (int l = 0; l < 25; l++)
         begin
            pulse(l);
            chk16(n[15:0], (l == route_idx(c)) ? 16'h1 : 16'h0);
         end
      end
      $display("test route done");
   endtask

   task automatic t_trigger;
      wr(4'h0, 16'h0000);
      wr(4'h1, 16'h0001);
      #1 chk1(unit_enabled, 1'b1);
      wr(4'h1, 16'h0000);
      #1 chk1(trigger_out, 1'b1);
      chk1(unit_enabled, 1'b0);
      @(posedge clk_sys);
      #1 chk1(trigger_out, 1'b0);
      wr(4'h1, 16'h0000);
      #1 chk1(trigger_out, 1'b0);
      $display("test trigger done");
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 7500 cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      print_verdict;
   end

   // Main sequence
   initial
   begin
      miscompares = 0;
      checked     = 0;
      rst         = 1'b1;
      req         = '0;
      fire        = '0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_field;
      t_status;
      t_route;
      t_trigger;
      print_verdict;
   end
endmodule // tb_top
